/* File: inc/rta_pkg.sv */
// constants and carriers for the remote target address remap block
package rta_pkg;
    localparam int         BUS_AW      = 8;
    localparam int         BUS_DW      = 8;
    localparam int         I2C_AW      = 7;
    localparam int         NUM_ALIAS   = 3;
    localparam int         SLOT_W      = 2;
    localparam int         FLD_MSB     = 7;
    localparam int         FLD_LSB     = 1;
    localparam logic [7:0] OFF_PHYS6   = 8'h0E;
    localparam logic [7:0] OFF_PHYS7   = 8'h0F;
    localparam logic [7:0] OFF_ALIAS0  = 8'h10;
    localparam logic [7:0] OFF_ALIAS1  = 8'h11;
    localparam logic [7:0] OFF_ALIAS2  = 8'h12;
    localparam logic [6:0] ADDR_RST    = 7'h00;
    localparam logic [6:0] ALIAS_OFF   = 7'h00;
    localparam logic [7:0] RDATA_IDLE  = 8'h00;
    localparam logic       RSVD_VAL    = 1'b0;

    typedef struct packed {
        logic [BUS_AW-1:0] addr;
        logic [BUS_DW-1:0] wdata;
        logic              wr;
        logic              rd;
    } rta_bus_t;

    typedef struct packed {
        logic              valid;
        logic [I2C_AW-1:0] addr;
        logic              rnw;
    } rta_req_t;

    typedef struct packed {
        logic              valid;
        logic [I2C_AW-1:0] addr;
        logic              rnw;
        logic [SLOT_W-1:0] slot;
    } rta_fwd_t;
endpackage : rta_pkg

/* File: core/rta_alias_match.sv */
// one alias slot comparator with zero-disable
module rta_alias_match
(
    input  wire logic [6:0] alias_addr,
    input  wire logic [6:0] req_addr,
    input  wire logic       req_valid,
    output logic            hit
);
    import rta_pkg::*;

    // a cleared alias never matches, even an all-zero request address
    assign hit = req_valid && (alias_addr != ALIAS_OFF)
                 && (req_addr == alias_addr);
endmodule : rta_alias_match

/* File: core/rta_remap.sv */
// register file and address remap for remote I2C targets
// Notes on behaviour
// - physical slots 6 and 7 hold a writable 7-bit target address in bits 7..1
// - request matching alias N is forwarded with physical slot N address
// - alias slots hold a writable 7-bit compare value in bits 7..1
// - an alias slot holding zero never forwards anything
// - all slots reset to zero; offsets 0xE, 0xF, 0x10, 0x11
// - alias slot 2 at 0x12 behaves the same, paired with physical slot 2
//
// The strobed register port was left to the implementer.
module rta_remap
(
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    input  wire rta_pkg::rta_bus_t             bus_i,
    output logic [rta_pkg::BUS_DW-1:0]         rd_data_o,
    input  wire logic [rta_pkg::NUM_ALIAS-1:0][rta_pkg::I2C_AW-1:0] phys_low_i,
    input  wire rta_pkg::rta_req_t             req_i,
    output rta_pkg::rta_fwd_t                  fwd_o,
    output logic [rta_pkg::I2C_AW-1:0]         phys6_o,
    output logic [rta_pkg::I2C_AW-1:0]         phys7_o
);
    import rta_pkg::*;

    // ============================================================
    // register storage
    logic [I2C_AW-1:0]                 phys6_q;
    logic [I2C_AW-1:0]                 phys7_q;
    logic [NUM_ALIAS-1:0][I2C_AW-1:0]  alias_q;
    logic [BUS_DW-1:0]                 rd_data_q;
    logic [BUS_DW-1:0]                 rd_data_d;
    logic [NUM_ALIAS-1:0]              hit;
    rta_fwd_t                          fwd_q;
    rta_fwd_t                          fwd_d;

    localparam logic [NUM_ALIAS-1:0][7:0] ALIAS_OFFS =
        {OFF_ALIAS2, OFF_ALIAS1, OFF_ALIAS0};

    // bit 0 of write data is dropped, so the reserved bit cannot be set
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            phys6_q <= ADDR_RST;
        else if (bus_i.wr && bus_i.addr == OFF_PHYS6)
            phys6_q <= bus_i.wdata[FLD_MSB:FLD_LSB];
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            phys7_q <= ADDR_RST;
        else if (bus_i.wr && bus_i.addr == OFF_PHYS7)
            phys7_q <= bus_i.wdata[FLD_MSB:FLD_LSB];
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_ALIAS; gi++)
        begin : g_alias
            always_ff @(posedge mclk)
            begin
                if (!rst_n)
                    alias_q[gi] <= ALIAS_OFF;
                else if (bus_i.wr && bus_i.addr == ALIAS_OFFS[gi])
                    alias_q[gi] <= bus_i.wdata[FLD_MSB:FLD_LSB];
            end

            rta_alias_match u_match
            (
                .alias_addr (alias_q[gi]),
                .req_addr   (req_i.addr),
                .req_valid  (req_i.valid),
                .hit        (hit[gi])
            );
        end
    endgenerate

    // ============================================================
    // read path
    always_comb
    begin
        rd_data_d = RDATA_IDLE;
        if (bus_i.rd)
        begin
            unique case (bus_i.addr)
                OFF_PHYS6:  rd_data_d = {phys6_q, RSVD_VAL};
                OFF_PHYS7:  rd_data_d = {phys7_q, RSVD_VAL};
                OFF_ALIAS0: rd_data_d = {alias_q[0], RSVD_VAL};
                OFF_ALIAS1: rd_data_d = {alias_q[1], RSVD_VAL};
                OFF_ALIAS2: rd_data_d = {alias_q[2], RSVD_VAL};
                default:    rd_data_d = RDATA_IDLE;
            endcase
        end
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            rd_data_q <= RDATA_IDLE;
        else
            rd_data_q <= rd_data_d;
    end

    // ============================================================
    // remap path
    // duplicate aliases resolve to the lowest slot so the result is defined
    always_comb
    begin
        fwd_d       = '0;
        fwd_d.rnw   = req_i.rnw;
        for (int i = NUM_ALIAS - 1; i >= 0; i--)
        begin
            if (hit[i])
            begin
                fwd_d.valid = 1'b1;
                fwd_d.addr  = phys_low_i[i];
                fwd_d.slot  = SLOT_W'(i);
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            fwd_q <= '0;
        else
            fwd_q <= fwd_d;
    end

    assign rd_data_o = rd_data_q;
    assign fwd_o     = fwd_q;
    assign phys6_o   = phys6_q;
    assign phys7_o   = phys7_q;

    // ============================================================
    // assertions
    property p_phys6_write;
        @(posedge mclk) disable iff (!rst_n)
        bus_i.wr && bus_i.addr == OFF_PHYS6
        |=> phys6_o == $past(bus_i.wdata[7:1]);
    endproperty
    a_phys6_write: assert property (p_phys6_write)
        else $error("physical slot 6 did not take written address");

    property p_phys7_readback;
        @(posedge mclk) disable iff (!rst_n)
        bus_i.wr && bus_i.addr == OFF_PHYS7 ##1
        bus_i.rd && bus_i.addr == OFF_PHYS7 && !bus_i.wr
        |=> rd_data_o == {$past(bus_i.wdata[7:1], 2), 1'b0};
    endproperty
    a_phys7_readback: assert property (p_phys7_readback)
        else $error("physical slot 7 read back wrong value");

    property p_remap_slot0;
        @(posedge mclk) disable iff (!rst_n)
        req_i.valid && alias_q[0] != 7'h00 && req_i.addr == alias_q[0]
        |=> fwd_o.valid && fwd_o.slot == 2'h0
            && fwd_o.addr == $past(phys_low_i[0]);
    endproperty
    a_remap_slot0: assert property (p_remap_slot0)
        else $error("alias 0 hit not remapped to physical slot 0");

    property p_remap_slot1;
        @(posedge mclk) disable iff (!rst_n)
        req_i.valid && alias_q[1] != 7'h00 && req_i.addr == alias_q[1]
        && req_i.addr != alias_q[0]
        |=> fwd_o.valid && fwd_o.slot == 2'h1
            && fwd_o.addr == $past(phys_low_i[1])
            && fwd_o.rnw == $past(req_i.rnw);
    endproperty
    a_remap_slot1: assert property (p_remap_slot1)
        else $error("alias 1 hit not remapped to physical slot 1");

    property p_alias_write;
        @(posedge mclk) disable iff (!rst_n)
        bus_i.wr && bus_i.addr == OFF_ALIAS1
        |=> alias_q[1] == $past(bus_i.wdata[7:1]);
    endproperty
    a_alias_write: assert property (p_alias_write)
        else $error("alias slot 1 did not take written value");

    property p_no_match_no_fwd;
        @(posedge mclk) disable iff (!rst_n)
        !req_i.valid
        || ((alias_q[0] == 7'h00 || req_i.addr != alias_q[0])
        &&  (alias_q[1] == 7'h00 || req_i.addr != alias_q[1])
        &&  (alias_q[2] == 7'h00 || req_i.addr != alias_q[2]))
        |=> !fwd_o.valid;
    endproperty
    a_no_match_no_fwd: assert property (p_no_match_no_fwd)
        else $error("request forwarded without an enabled alias match");

    property p_reset_clear;
        @(posedge mclk)
        !rst_n |=> phys6_o == 7'h00 && phys7_o == 7'h00
            && alias_q == '0 && !fwd_o.valid;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("slots not zero after reset");

    // alias 2 is loaded only through its own offset, so a hit covers both
    property p_alias2_map;
        @(posedge mclk) disable iff (!rst_n)
        req_i.valid && alias_q[2] != 7'h00 && req_i.addr == alias_q[2]
            && req_i.addr != alias_q[0] && req_i.addr != alias_q[1]
        |=> fwd_o.valid && fwd_o.slot == 2'h2
            && fwd_o.addr == $past(phys_low_i[2])
            && fwd_o.rnw == $past(req_i.rnw);
    endproperty
    a_alias2_map: assert property (p_alias2_map)
        else $error("alias 2 at its offset not remapped to slot 2");

    property p_rsvd_zero;
        @(posedge mclk) disable iff (!rst_n)
        bus_i.rd |=> rd_data_o[0] == 1'b0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved bit 0 read as one");

    property p_idle_rdata;
        @(posedge mclk) disable iff (!rst_n)
        !bus_i.rd |=> rd_data_o == 8'h00;
    endproperty
    a_idle_rdata: assert property (p_idle_rdata)
        else $error("read data present without a read");

    c_remap0: cover property (@(posedge mclk) disable iff (!rst_n)
        fwd_o.valid && fwd_o.slot == 2'h0);
    c_remap2: cover property (@(posedge mclk) disable iff (!rst_n)
        fwd_o.valid && fwd_o.slot == 2'h2);
    c_disabled: cover property (@(posedge mclk) disable iff (!rst_n)
        req_i.valid && alias_q[1] == 7'h00 && req_i.addr == 7'h00);
    c_readback: cover property (@(posedge mclk) disable iff (!rst_n)
        bus_i.rd && bus_i.addr == OFF_ALIAS1 ##1 rd_data_o != 8'h00);
endmodule : rta_remap

/* File: verif/rta_ctl_model.sv */
// model of the local i2c controller and the far-side address holder
module rta_ctl_model
    import rta_pkg::*;
(
    input  wire logic                         mclk,
    output rta_req_t                          req,
    output logic [NUM_ALIAS-1:0][I2C_AW-1:0] phys_low
);
    timeunit 1ns;
    timeprecision 1ps;
    // ================================================================
    // address phases
    initial
    begin
        req      = '0;
        phys_low = {7'h33, 7'h22, 7'h11};
    end
    // address inverted once released so a stale value never matches
    task automatic send(input logic [I2C_AW-1:0] a, input logic rnw);
        @(posedge mclk);
        req <= '{valid: 1'b1, addr: a, rnw: rnw};
        @(posedge mclk);
        req <= '{valid: 1'b0, addr: ~a, rnw: ~rnw};
    endtask : send
endmodule : rta_ctl_model

/* File: verif/tb_top.sv */
// self-checking bench for the remote target address remap block
module tb_top
    import rta_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                         mclk;
    logic                         rst_n;
    rta_bus_t                     bus;
    logic [7:0]                   rd_data;
    rta_req_t                     req;
    logic [NUM_ALIAS-1:0][I2C_AW-1:0] phys_low;
    rta_fwd_t                     fwd;
    logic [6:0]                   phys6;
    logic [6:0]                   phys7;
    int                           n_fail;
    int                           check_count;
    int                           cycles;
    localparam rta_fwd_t NO_FWD = '{1'b0, 7'h00, 1'b1, 2'd0};
    // ================================================================
    // harness
    rta_remap DUT (.mclk(mclk), .rst_n(rst_n), .bus_i(bus),
        .rd_data_o(rd_data), .phys_low_i(phys_low), .req_i(req),
        .fwd_o(fwd), .phys6_o(phys6), .phys7_o(phys7));
    rta_ctl_model FAR (.mclk(mclk), .req(req), .phys_low(phys_low));
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_fail++;
            stop_test();
        end
    end
    // ================================================================
    // shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 chk(rd_data, exp, "read data");
    endtask : reg_rd
    // the direction bit of the request follows the expected copy
    task automatic req_chk(input logic [6:0] a, input rta_fwd_t exp);
        FAR.send(a, exp.rnw);
        #1 chk(fwd, exp, "forward");
    endtask : req_chk
    // ================================================================
    // scenarios
    task automatic t_reset;
        for (int i = 0; i < 5; i++)
            reg_rd(OFF_PHYS6 + 8'(i), 8'h00);
        chk({phys6, phys7}, 14'h0000, "phys outputs");
        $display("test reset done");
    endtask : t_reset
    task automatic t_regs;
        reg_wr(OFF_PHYS6, 8'hA5);
        reg_wr(OFF_PHYS7, 8'hFF);
        reg_wr(OFF_ALIAS0, 8'h55);
        reg_wr(8'h13, 8'hFF);
        reg_rd(OFF_PHYS6, 8'hA4);
        reg_rd(OFF_PHYS7, 8'hFE);
        reg_rd(OFF_ALIAS0, 8'h54);
        reg_rd(8'h13, 8'h00);
        // write then read with no gap, as the bus allows
        @(posedge mclk);
        bus <= '{addr: OFF_PHYS7, wdata: 8'h81, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus <= '{addr: OFF_PHYS7, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 chk(rd_data, 8'h80, "read right after write");
        @(posedge mclk);
        #1 chk(rd_data, 8'h00, "read after answer");
        chk({phys6, phys7}, {7'h52, 7'h40}, "phys outputs");
        $display("test registers done");
    endtask : t_regs
    task automatic t_remap;
        reg_wr(OFF_ALIAS0, 8'h54);
        reg_wr(OFF_ALIAS1, 8'h62);
        reg_wr(OFF_ALIAS2, 8'h2A);
        reg_rd(OFF_ALIAS1, 8'h62);
        reg_rd(OFF_ALIAS2, 8'h2A);
        req_chk(7'h2A, '{1'b1, 7'h11, 1'b1, 2'd0});
        req_chk(7'h31, '{1'b1, 7'h22, 1'b1, 2'd1});
        req_chk(7'h15, '{1'b1, 7'h33, 1'b1, 2'd2});
        req_chk(7'h15, '{1'b1, 7'h33, 1'b0, 2'd2});
        req_chk(7'h40, NO_FWD);
        $display("test remap done");
    endtask : t_remap
    task automatic t_zero;
        // only the reserved bit set, so the slot field becomes zero
        reg_wr(OFF_ALIAS1, 8'h01);
        req_chk(7'h31, NO_FWD);
        req_chk(7'h00, NO_FWD);
        reg_rd(OFF_ALIAS1, 8'h00);
        req_chk(7'h2A, '{1'b1, 7'h11, 1'b1, 2'd0});
        $display("test zero disable done");
    endtask : t_zero
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    // ================================================================
    // main sequence
    initial
    begin
        n_fail      = 0;
        check_count = 0;
        cycles      = 0;
        bus         = '0;
        rst_n       = 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_regs();
        t_remap();
        t_zero();
        stop_test();
    end
endmodule : tb_top
